// ---- logic/ddrx_defs.svh ----
// Constants for the burst order and extended mode one decode block
// Assumes inclusion by the top module only, not by logic/ddrx_pkg.sv
`ifndef DDRX_DEFS_SVH
`define DDRX_DEFS_SVH

// ****************************************************************
// Field positions of extended mode one (address lines)
// ****************************************************************
`define DDRX_EM1_DLL_BIT      0
`define DDRX_EM1_DRV_BIT      1
`define DDRX_EM1_RTT_LO_BIT   2
`define DDRX_EM1_PCD_LSB      3
`define DDRX_EM1_PCD_MSB      5
`define DDRX_EM1_RTT_HI_BIT   6
`define DDRX_EM1_CAL_LSB      7
`define DDRX_EM1_CAL_MSB      9
`define DDRX_EM1_NSTB_BIT     10
`define DDRX_EM1_RSTB_BIT     11
`define DDRX_EM1_QOFF_BIT     12
`define DDRX_EM1_WIDTH        13
`define DDRX_EM1_RESET        13'h0000

// ****************************************************************
// Main mode register fields and the posted delay limit used here
// ****************************************************************
`define DDRX_MM_BT_BIT        3
`define DDRX_MM_BL4_CODE      3'h2
`define DDRX_PCD_MAX_CODE     3'h5

// ****************************************************************
// Timing
// ****************************************************************
`define DDRX_LOCK_CYCLES      200
`define DDRX_LOCK_W           8

`endif

// ---- logic/ddrx_pkg.sv ----
// Types for the burst order and extended mode one decode block
// Assumes nothing beyond the constants header
package ddrx_pkg;
  typedef enum logic [1:0] {
    DDRX_RTT_OFF = 2'b00,
    DDRX_RTT_75  = 2'b01,
    DDRX_RTT_150 = 2'b10,
    DDRX_RTT_50  = 2'b11
  } ddrx_rtt_t;

  typedef enum logic [2:0] {
    DDRX_CAL_EXIT    = 3'b000,
    DDRX_CAL_DRIVE1  = 3'b001,
    DDRX_CAL_DRIVE0  = 3'b010,
    DDRX_CAL_ADJUST  = 3'b100,
    DDRX_CAL_DEFAULT = 3'b111
  } ddrx_cal_t;

  typedef enum logic [1:0] {
    DDRX_BST_IDLE = 2'b00,
    DDRX_BST_RUN  = 2'b01
  } ddrx_bst_t;
endpackage

// ---- logic/ddrx_burst_em1.sv ----
// Burst column order generator and extended mode one register decode
// Assumes command pins synchronous to clk_i and a well-behaved controller
// How it works
// - Burst four: sequential rotates modulo four, interleave XORs start with 0..3
// - Burst eight sequential: rotate in start nibble, then other nibble same way
// - Burst eight interleave: start address XOR 0..7 in order
// - Register written when all command pins low, bank0 high, bank1 low
// - Delay loop off during self refresh, back on at exit
// - Bit 0 low enables delay loop, high disables
// - Bit 1 selects drive strength; bits 5:3 posted delay 0..5, rest reserved
// - Bits 6,2 select termination off, 75, 150, 50 ohm
// - Bits 9:7 select calibration exit, drive, adjust or default
// - Bit 11 read strobe on mask pin, bit 10 floats complements, bit 12 quiets outputs
// - Main register bit 3 chooses order, bits 2:0 choose length
`timescale 1ns/1ps
`include "ddrx_defs.svh"

module ddrx_burst_em1
  import ddrx_pkg::*;
(
  input  wire logic                       clk_i,          // 100 MHz clock
  input  wire logic                       sys_rst_i,      // Sync reset, high
  input  wire logic                       cke_i,          // Clock enable
  input  wire logic                       cs_n_i,         // Chip select, low
  input  wire logic                       ras_n_i,        // Row strobe, low
  input  wire logic                       cas_n_i,        // Column strobe, low
  input  wire logic                       we_n_i,         // Write enable, low
  input  wire logic [1:0]                 ba_i,           // Bank address
  input  wire logic [12:0]                addr_i,         // Address lines
  input  wire logic [3:0]                 main_mode_i,    // Main mode bits 3:0
  input  wire logic                       burst_start_i,  // Start a burst
  input  wire logic [2:0]                 start_col_i,    // Starting column bits
  output logic                            col_valid_o,    // Column offset valid
  output logic [2:0]                      col_o,          // Column offset
  output logic                            burst_last_o,   // Last beat of burst
  output logic                            dll_on_o,       // Delay loop running
  output logic                            dll_locked_o,   // Lock wait elapsed
  output logic                            drive_reduced_o,// Reduced drive
  output logic [2:0]                      post_delay_o,   // Posted delay, clocks
  output logic                            post_delay_rsv_o,// Reserved delay code
  output ddrx_rtt_t                       rtt_o,          // Termination select
  output ddrx_cal_t                       cal_o,          // Calibration operation
  output logic                            cal_rsv_o,      // Undefined cal code
  output logic                            rd_strobe_o,    // Mask pin is strobe
  output logic                            nstrobe_off_o,  // Complements floated
  output logic                            outputs_off_o,  // Output buffers off
  output logic                            self_ref_o      // In self refresh
);

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic                         em1_wr;
  logic                         sr_entry;
  logic                         sr_exit;
  logic                         cke_q_r;
  logic [`DDRX_EM1_WIDTH-1:0]   em1_r;
  logic                         sr_r;

  // Extended mode one write command
  assign em1_wr = cke_i & cke_q_r & ~cs_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i
                  & ba_i[0] & ~ba_i[1];
  // Self refresh entry and exit
  assign sr_entry = cke_q_r & ~cke_i & ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i;
  assign sr_exit  = sr_r & cke_i;

  // Previous clock enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cke_q_r <= 1'b1;                                           // Idle level, no false edge
    end else begin
      cke_q_r <= cke_i;
    end
  end

  // Register store
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      em1_r <= `DDRX_EM1_RESET;
    end else if (em1_wr) begin
      em1_r <= addr_i;
    end
  end

  // Self refresh state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sr_r <= 1'b0;
    end else if (sr_entry) begin
      sr_r <= 1'b1;
    end else if (sr_exit) begin
      sr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic                   dll_want;
  logic [2:0]             pcd;
  logic [2:0]             cal;
  assign dll_want = ~em1_r[`DDRX_EM1_DLL_BIT] & ~sr_r;
  assign pcd      = em1_r[`DDRX_EM1_PCD_MSB:`DDRX_EM1_PCD_LSB];
  assign cal      = em1_r[`DDRX_EM1_CAL_MSB:`DDRX_EM1_CAL_LSB];

  // Decoded outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dll_on_o         <= 1'b0;
      drive_reduced_o  <= 1'b0;
      post_delay_o     <= 3'h0;
      post_delay_rsv_o <= 1'b0;
      rtt_o            <= DDRX_RTT_OFF;
      cal_o            <= DDRX_CAL_EXIT;
      cal_rsv_o        <= 1'b0;
      rd_strobe_o      <= 1'b0;
      nstrobe_off_o    <= 1'b0;
      outputs_off_o    <= 1'b0;
      self_ref_o       <= 1'b0;
    end else begin
      dll_on_o         <= dll_want;
      drive_reduced_o  <= em1_r[`DDRX_EM1_DRV_BIT];
      post_delay_rsv_o <= (pcd > `DDRX_PCD_MAX_CODE);
      post_delay_o     <= (pcd > `DDRX_PCD_MAX_CODE) ? 3'h0 : pcd;
      rtt_o            <= ddrx_rtt_t'({em1_r[`DDRX_EM1_RTT_HI_BIT],
                                       em1_r[`DDRX_EM1_RTT_LO_BIT]});
      cal_o            <= ddrx_cal_t'(cal);
      cal_rsv_o        <= (cal == 3'h3) | (cal == 3'h5) | (cal == 3'h6);
      rd_strobe_o      <= em1_r[`DDRX_EM1_RSTB_BIT];
      nstrobe_off_o    <= em1_r[`DDRX_EM1_NSTB_BIT];
      outputs_off_o    <= em1_r[`DDRX_EM1_QOFF_BIT];
      self_ref_o       <= sr_r;
    end
  end

  // ****************************************************************
  // Delay loop lock wait
  // ****************************************************************
  logic [`DDRX_LOCK_W-1:0] lock_cnt_r;

  // Counts lock cycles after the loop (re)starts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_cnt_r   <= '0;
      dll_locked_o <= 1'b0;
    end else if (!dll_want) begin
      lock_cnt_r   <= '0;
      dll_locked_o <= 1'b0;
    end else if (lock_cnt_r != `DDRX_LOCK_W'(`DDRX_LOCK_CYCLES)) begin
      lock_cnt_r   <= lock_cnt_r + 1'b1;
      dll_locked_o <= 1'b0;
    end else begin
      dll_locked_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Burst column order
  // ****************************************************************
  ddrx_bst_t  bst_r;
  logic [2:0] beat_r;
  logic [2:0] start_r;
  logic       bl8_r;
  logic       ilv_r;

  // Column offset for a beat
  function automatic logic [2:0] col_of(input logic [2:0] st, input logic [2:0] bt,
                                        input logic bl8, input logic ilv);
    logic [2:0] c;
    c = 3'h0;
    if (ilv) begin
      c = st ^ bt;
    end else begin
      c[1:0] = st[1:0] + bt[1:0];
      c[2]   = st[2] ^ bt[2];
    end
    if (!bl8) begin
      c[2] = st[2];
    end
    return c;
  endfunction

  // Burst sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bst_r        <= DDRX_BST_IDLE;
      beat_r       <= 3'h0;
      start_r      <= 3'h0;
      bl8_r        <= 1'b0;
      ilv_r        <= 1'b0;
      col_valid_o  <= 1'b0;
      col_o        <= 3'h0;
      burst_last_o <= 1'b0;
    end else begin
      case (bst_r)
        DDRX_BST_IDLE: begin
          col_valid_o  <= 1'b0;
          burst_last_o <= 1'b0;
          if (burst_start_i) begin
            start_r <= start_col_i;
            bl8_r   <= (main_mode_i[2:0] != `DDRX_MM_BL4_CODE);
            ilv_r   <= main_mode_i[`DDRX_MM_BT_BIT];
            beat_r  <= 3'h0;
            bst_r   <= DDRX_BST_RUN;
          end
        end
        DDRX_BST_RUN: begin
          col_valid_o  <= 1'b1;
          col_o        <= col_of(start_r, beat_r, bl8_r, ilv_r);
          burst_last_o <= (beat_r == {bl8_r, 2'b11});
          beat_r       <= beat_r + 3'h1;
          if (beat_r == {bl8_r, 2'b11}) begin
            bst_r <= DDRX_BST_IDLE;
          end
        end
        default: begin
          bst_r <= DDRX_BST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_em1_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    em1_wr |=> (em1_r == $past(addr_i))) else $error("register write lost");
  chk_sr_dll_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sr_r |=> !dll_on_o) else $error("loop on in self refresh");
  chk_dll_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (em1_r[0] && $stable(em1_r)) |=> !dll_on_o) else $error("loop on while disabled");
  chk_pcd_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pcd <= 3'h5) |=> (post_delay_o == $past(pcd))) else $error("posted delay wrong");
  chk_rtt_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (rtt_o == {$past(em1_r[6]), $past(em1_r[2])})) else $error("termination wrong");
  chk_cal_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (cal_o == $past(cal))) else $error("calibration wrong");
  chk_qoff_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (outputs_off_o == $past(em1_r[12]))) else $error("output disable wrong");
  chk_ilv_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bst_r == DDRX_BST_RUN && ilv_r && bl8_r) |=> (col_o == ($past(start_r) ^ $past(beat_r))))
    else $error("interleave order wrong");
  chk_seq_nibble: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bst_r == DDRX_BST_RUN && !ilv_r && beat_r == 3'h4) |=> (col_o[2] != $past(start_r[2])))
    else $error("nibble not switched");
  chk_bl4_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bst_r == DDRX_BST_IDLE && burst_start_i && main_mode_i[2:0] == 3'h2)
    |=> ##4 burst_last_o) else $error("burst four length wrong");
  chk_lock_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(dll_locked_o) |-> (lock_cnt_r == `DDRX_LOCK_W'(`DDRX_LOCK_CYCLES))) else $error("lock too early");

endmodule

// ---- testbench/ddrx_ctrl_model.sv ----
// Memory controller model driving the command and address pins
// Assumes the testbench calls its tasks one at a time on clk_i
`timescale 1ns/1ps

module ddrx_ctrl_model #(
  parameter bit WIDE16 = 1'b0                    // Sixteen-bit organisation
) (
  input  wire logic        clk_i,                // Device clock
  output logic             cke_o,                // Clock enable
  output logic [3:0]       cmd_n_o,              // cs, ras, cas, we
  output logic [1:0]       ba_o,                 // Bank address
  output logic [12:0]      addr_o                // Address lines
);
  // ****************************************************************
  // Command tasks
  // ****************************************************************
  // Idle: deselected, clock enable held high
  initial begin
    cke_o   = 1'b1;
    cmd_n_o = 4'hF;
    ba_o    = 2'h0;
    addr_o  = 13'h0000;
  end

  // Mode set; deselected lines flip to the inverse value
  task automatic mrs(input logic [1:0] ba, input logic [12:0] val);
    logic [12:0] v;
    v = val;
    if (WIDE16) begin
      v[11] = 1'b0;
    end
    @(posedge clk_i);
    cke_o   <= 1'b1;
    cmd_n_o <= 4'h0;
    ba_o    <= ba;
    addr_o  <= v;
    @(posedge clk_i);
    cmd_n_o <= 4'hF;
    ba_o    <= ~ba;
    addr_o  <= ~v;
    repeat (2) @(posedge clk_i);
  endtask

  // Self refresh entry, clock enable dropped with the command
  task automatic sref_enter();
    @(posedge clk_i);
    cke_o   <= 1'b0;
    cmd_n_o <= 4'h1;
    @(posedge clk_i);
    cmd_n_o <= 4'hF;
    repeat (2) @(posedge clk_i);
  endtask

  // Self refresh exit with chip deselected
  task automatic sref_exit();
    @(posedge clk_i);
    cke_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for burst order and extended mode one decode
// Assumes ddrx_burst_em1 and the controller model are compiled first
`timescale 1ns/1ps

module testbench;
  import ddrx_pkg::*;
  logic        clk_i, sys_rst_i, cke, mstart, valid, last, dll_on, locked;
  logic        drv, pd_rsv, cal_rsv, rd_stb, nstb, qoff, sref;
  logic [3:0]  cmd_n, mmode;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic [2:0]  scol, col, pd;
  ddrx_rtt_t   rtt;
  ddrx_cal_t   cal;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // ****************************************************************
  // Clock, reset, instances
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ddrx_ctrl_model u_ctrl (.clk_i(clk_i), .cke_o(cke), .cmd_n_o(cmd_n), .ba_o(ba), .addr_o(addr));

  ddrx_burst_em1 u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke), .cs_n_i(cmd_n[3]),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .ba_i(ba), .addr_i(addr),
    .main_mode_i(mmode), .burst_start_i(mstart), .start_col_i(scol), .col_valid_o(valid),
    .col_o(col), .burst_last_o(last), .dll_on_o(dll_on), .dll_locked_o(locked),
    .drive_reduced_o(drv), .post_delay_o(pd), .post_delay_rsv_o(pd_rsv), .rtt_o(rtt),
    .cal_o(cal), .cal_rsv_o(cal_rsv), .rd_strobe_o(rd_stb), .nstrobe_off_o(nstb),
    .outputs_off_o(qoff), .self_ref_o(sref));

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Decoded fields against a written value
  task automatic em1_check(input logic [12:0] v);
    logic [2:0] p;
    logic [2:0] c;
    p = v[5:3];
    c = v[9:7];
    @(negedge clk_i);
    chk("dll_on", 13'(!v[0]), 13'(dll_on));
    chk("drive", 13'(v[1]), 13'(drv));
    chk("delay", 13'((p > 3'h5) ? 3'h0 : p), 13'(pd));
    chk("delay_rsv", 13'(p > 3'h5), 13'(pd_rsv));
    chk("rtt", 13'({v[6], v[2]}), 13'(rtt));
    chk("cal", 13'(c), 13'(cal));
    chk("cal_rsv", 13'(c == 3'h3 || c == 3'h5 || c == 3'h6), 13'(cal_rsv));
    chk("strobes", 13'(v[12:10]), 13'({qoff, rd_stb, nstb}));
  endtask

  // Every field code except delay loop disable, then writes to other banks that must be ignored
  task automatic test_fields();
    logic [2:0]  i;
    logic [12:0] v;
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      v = {i, i, i[1] ^ i[0], i, i[0], i[1], 1'b0};
      u_ctrl.mrs(2'h1, v);
      em1_check(v);
    end
    u_ctrl.mrs(2'h2, ~v);
    u_ctrl.mrs(2'h0, ~v);
    em1_check(v);
  endtask

  // Loop disable, enable with lock wait, self refresh round trip
  task automatic test_dll();
    int n;
    u_ctrl.mrs(2'h1, 13'h0001);
    em1_check(13'h0001);
    chk("locked_off", 13'h0, 13'(locked));
    u_ctrl.mrs(2'h1, 13'h0000);
    n = 0;
    @(negedge clk_i);
    while (locked !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("lock_wait", 13'h1, 13'(n >= 198 && n <= 201));
    u_ctrl.sref_enter();
    @(negedge clk_i);
    chk("sref_in", 13'h2, 13'({sref, dll_on}));
    u_ctrl.sref_exit();
    @(negedge clk_i);
    chk("sref_out", 13'h2, 13'({sref, dll_on, locked}));
  endtask

  // One burst; poke retries a start mid-burst, which must be ignored
  task automatic run_burst(input logic bl8, input logic ilv, input logic [2:0] st, input bit poke);
    logic [2:0] k;
    logic [2:0] e;
    logic [2:0] m;
    int         nb;
    nb = bl8 ? 8 : 4;
    m = bl8 ? 3'h7 : 3'h3;
    @(posedge clk_i);
    mmode  <= {ilv, bl8 ? 3'h3 : 3'h2};
    mstart <= 1'b1;
    scol   <= st;
    @(posedge clk_i);
    mstart <= 1'b0;
    scol   <= ~st;
    @(posedge clk_i);
    for (int b = 0; b < nb; b++) begin
      k = 3'(b);
      e = ilv ? (st ^ k) : {st[2] ^ k[2], st[1:0] + k[1:0]};
      @(negedge clk_i);
      chk("valid", 13'h1, 13'(valid));
      chk("col", 13'(e & m), 13'(col & m));
      chk("last", 13'(b == nb - 1), 13'(last));
      @(posedge clk_i);
      mstart <= poke && b == 1;
    end
    @(negedge clk_i);
    chk("valid_end", 13'h0, 13'(valid));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst_i = 1'b1;
    mstart    = 1'b0;
    scol      = 3'h0;
    mmode     = 4'h2;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset", 13'h0, 13'({valid, dll_on, locked}));
    test_fields();
    for (int md = 0; md < 4; md++) begin
      for (int s = 0; s < 8; s++) begin
        run_burst(md[1], md[0], 3'(s), md == 3 && s == 5);
      end
    end
    test_dll();
    final_report();
  end
endmodule
